/* File: src/watchdog_interval_timer.sv */
// Purpose: supervision timer with watchdog and interval timer modes
// Assumes: APB slave, 32-bit data, low-speed clock arrives as a level on LS_CLK
// Notes: counter is not readable; reset cause survives the core reset
//
// How it works
// - 15-bit up-counter advanced by low-speed clock ticks, never readable.
// - after reset timer disabled, watchdog mode, all control fields zero.
// - control bit 2 selects watchdog (0) or timer (1) mode.
// - writing 1 to bit 3 enables and starts counting on ticks.
// - running watchdog ignores a write of 0 to enable.
// - running watchdog ignores writes to mode select.
// - interval code 00/01/10/11 gives 32768/8192/512/64 tick periods.
// - watchdog mode at terminal count asserts a system reset.
// - key 0xA then 0x5 within half a tick period clears counter.
// - sequence started before terminal count clears counter on completion.
// - clear field writes ignored while disabled.
// - clear field always reads back as zero.
// - interval stays writable in running watchdog, applies at once.
// - watchdog mode never raises the interrupt request.
// - timer mode at terminal count raises an interrupt request.
// - timer mode never asserts a system reset.
// - timer mode, writing 1 to clear bit 0 zeroes counter.
// - timer mode, enable 0 stops; enable 1 restarts from zero.
// - supply detectors hold chip in reset until supply is good.
// - cause of the latest reset is readable and updated each reset.
// - cause code 00 power-on, 01 external, 10 watchdog.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module watchdog_interval_timer import wit_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic LS_CLK,
  input wire logic POWER_ON_OK_N,
  input wire logic SUPPLY_DIP_RESET_N,
  input wire logic EXT_RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic TIMER_IRQ,
  output logic SYS_RESET_N
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wit_ctl_t ctl;
    logic [CNT_W-1:0] cnt;
    logic armed;
    logic [KEY_WIN_W-1:0] win;
    logic ls_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic fire;
  } wit_core_st_t;

  wit_core_st_t st_r;
  wit_core_st_t st_nxt;
  logic ls_lvl;
  logic ls_tick;
  logic [CNT_W-1:0] lim;
  logic [1:0] cause;
  logic acc;
  logic hit_ctl;
  logic hit_stat;
  logic locked;
  wit_ctl_t wd;

  // ---------------------------------------------------------------
  // low-speed clock crossing
  // ---------------------------------------------------------------
  // slow clock only ever seen as a synchronised level
  wit_sync #(.W(1)) u_ls_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .din(LS_CLK),
    .dout(ls_lvl)
  );

  // one core cycle per rising slow edge
  assign ls_tick = ls_lvl & ~st_r.ls_prev;

  // ---------------------------------------------------------------
  // reset generation and cause
  // ---------------------------------------------------------------
  wit_rstgen u_rstgen (
    .clk(CORE_CLK),
    .power_on_ok_n(POWER_ON_OK_N),
    .supply_dip_reset_n(SUPPLY_DIP_RESET_N),
    .ext_reset_n(EXT_RESET_N),
    .wdog_fire(st_r.fire),
    .sys_reset_n(SYS_RESET_N),
    .cause(cause)
  );

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // terminal count per interval code
  always_comb begin
    case (st_r.ctl.intv)
      2'b00: lim = LIM_32768;
      2'b01: lim = LIM_8192;
      2'b10: lim = LIM_512;
      2'b11: lim = LIM_64;
      default: lim = LIM_32768;
    endcase
  end

  // bus decode
  assign acc = PSEL & PENABLE;
  assign hit_ctl = (PADDR == CTRL_ADDR);
  assign hit_stat = (PADDR == STAT_ADDR);
  assign wd = PWDATA[7:0];
  // running watchdog freezes enable and mode
  assign locked = st_r.ctl.en & (st_r.ctl.mode == MODE_WDOG);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.irq = 1'b0;
    st_nxt.fire = 1'b0;
    st_nxt.ls_prev = ls_lvl;

    // key window runs down in core cycles
    if (st_r.win != '0) begin
      st_nxt.win = st_r.win - KEY_WIN_W'(1);
    end else begin
      st_nxt.armed = 1'b0;
    end

    // counter advance and terminal event
    if (st_r.ctl.en && ls_tick) begin
      if (st_r.cnt == lim) begin
        st_nxt.cnt = '0;
        if (st_r.ctl.mode == MODE_WDOG) begin
          st_nxt.fire = 1'b1;
        end else begin
          st_nxt.irq = 1'b1;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end

    // first access cycle: answer next cycle
    if (acc && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = '0;
      if (hit_ctl) begin
        // clear field and counter never read back
        st_nxt.prdata[CTL_EN_BIT] = st_r.ctl.en;
        st_nxt.prdata[CTL_MODE_BIT] = st_r.ctl.mode;
        st_nxt.prdata[CTL_INT_LSB +: 2] = st_r.ctl.intv;
      end else if (hit_stat) begin
        st_nxt.prdata[STAT_CAUSE_LSB +: 2] = cause;
        st_nxt.prdata[STAT_RUN_BIT] = st_r.ctl.en;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end

    // write takes effect at the edge that sees pready high
    if (acc && st_r.pready && PWRITE && hit_ctl && PSTRB[0]) begin
      st_nxt.ctl.intv = wd.intv;
      if (!locked) begin
        st_nxt.ctl.mode = wd.mode;
        st_nxt.ctl.en = wd.en;
        if (wd.en && !st_r.ctl.en) begin
          st_nxt.cnt = '0;
        end
      end
      // clear field, only while enabled
      if (st_r.ctl.en) begin
        if (st_r.ctl.mode == MODE_TIMER) begin
          if (wd.key[0]) begin
            st_nxt.cnt = '0;
          end
        end else if (wd.key == KEY_SECOND && st_r.armed) begin
          st_nxt.cnt = '0;
          st_nxt.armed = 1'b0;
        end else if (wd.key == KEY_FIRST) begin
          st_nxt.armed = 1'b1;
          st_nxt.win = KEY_WIN_W'(KEY_WIN_CYC);
        end else begin
          st_nxt.armed = 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // synchronous reset: disabled, watchdog mode, fields zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.ctl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign TIMER_IRQ = st_r.irq;

endmodule // watchdog_interval_timer

/* File: src/wit_pkg.sv */
// Purpose: shared constants and types for the supervision timer block
// Assumes: 200 MHz core clock, 32.768 kHz low-speed clock sampled as a level
// Notes: register indices are word indices; byte address is four times index
package wit_pkg;

  // ---------------------------------------------------------------
  // clocks and timing
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 200_000_000;
  localparam int unsigned LS_CLK_HZ = 32_768;
  // clear key window, in tenths of a low-speed period (0.5 period)
  localparam int unsigned KEY_WIN_TENTHS = 5;
  // longest time, rounded down to whole core cycles
  localparam int unsigned KEY_WIN_CYC = (CORE_CLK_HZ / 10 * KEY_WIN_TENTHS) / LS_CLK_HZ;
  localparam int unsigned KEY_WIN_W = 12;
  // system reset stretch after a watchdog expiry, core cycles
  localparam logic [4:0] WDOG_RST_CYC = 5'h10;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [9:0] CTRL_IDX = 10'h0C9;
  localparam logic [9:0] STAT_IDX = 10'h0CA;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [7:0] CTRL_RST = 8'h00;

  // control field positions
  localparam int unsigned CTL_INT_LSB = 0;
  localparam int unsigned CTL_MODE_BIT = 2;
  localparam int unsigned CTL_EN_BIT = 3;
  localparam int unsigned CTL_KEY_LSB = 4;
  // status field positions
  localparam int unsigned STAT_CAUSE_LSB = 0;
  localparam int unsigned STAT_RUN_BIT = 2;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic MODE_WDOG = 1'b0;
  localparam logic MODE_TIMER = 1'b1;
  localparam logic [3:0] KEY_FIRST = 4'hA;
  localparam logic [3:0] KEY_SECOND = 4'h5;
  localparam logic [1:0] CAUSE_POR = 2'b00;
  localparam logic [1:0] CAUSE_EXT = 2'b01;
  localparam logic [1:0] CAUSE_WDOG = 2'b10;

  // terminal counts minus one, per interval code
  localparam int unsigned CNT_W = 15;
  localparam logic [14:0] LIM_32768 = 15'h7FFF;
  localparam logic [14:0] LIM_8192 = 15'h1FFF;
  localparam logic [14:0] LIM_512 = 15'h01FF;
  localparam logic [14:0] LIM_64 = 15'h003F;

  // control register layout, msb first
  typedef struct packed {
    logic [3:0] key;
    logic en;
    logic mode;
    logic [1:0] intv;
  } wit_ctl_t;

endpackage

/* File: src/wit_rstgen.sv */
// Purpose: system reset generation and reset cause record
// Assumes: power-on and supply dip indications are active low levels
// Notes: held in its own reset by the supply detectors, not by the core reset
`timescale 1ns/1ps
module wit_rstgen import wit_pkg::*; (
  input wire logic clk,
  input wire logic power_on_ok_n,
  input wire logic supply_dip_reset_n,
  input wire logic ext_reset_n,
  input wire logic wdog_fire,
  output logic sys_reset_n,
  output logic [1:0] cause
);

  typedef struct packed {
    logic [1:0] cause;
    logic [4:0] stretch;
    logic rst_n;
  } wit_rst_st_t;

  wit_rst_st_t rg_r;
  wit_rst_st_t rg_nxt;

  // pick the latest reset source and stretch watchdog resets
  always_comb begin
    rg_nxt = rg_r;
    if (!ext_reset_n) begin
      rg_nxt.cause = CAUSE_EXT;
      rg_nxt.stretch = '0;
      rg_nxt.rst_n = 1'b0;
    end else if (wdog_fire) begin
      rg_nxt.cause = CAUSE_WDOG;
      rg_nxt.stretch = WDOG_RST_CYC;
      rg_nxt.rst_n = 1'b0;
    end else if (rg_r.stretch != 5'h00) begin
      rg_nxt.stretch = rg_r.stretch - 5'h01;
      rg_nxt.rst_n = 1'b0;
    end else begin
      rg_nxt.rst_n = 1'b1;
    end
  end

  // supply detectors hold everything, cause forced to power-on
  always_ff @(posedge clk) begin
    if (!power_on_ok_n || !supply_dip_reset_n) begin
      rg_r <= {CAUSE_POR, 5'h00, 1'b0};
    end else begin
      rg_r <= rg_nxt;
    end
  end

  assign sys_reset_n = rg_r.rst_n;
  assign cause = rg_r.cause;

endmodule // wit_rstgen

/* File: src/wit_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: input may change at any time relative to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module wit_sync import wit_pkg::*; #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wit_sync_st_t;

  wit_sync_st_t sync_r;
  wit_sync_st_t sync_nxt;

  // shift the level through two stages
  always_comb begin
    sync_nxt = sync_r;
    sync_nxt.s1 = din;
    sync_nxt.s2 = sync_r.s1;
  end

  // synchronous reset to zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r.s2;

endmodule // wit_sync

/* File: test/watchdog_interval_timer_test.sv */
// Purpose: self-checking bench for the supervision timer
// Assumes: slow clock built from the core clock, LSP cycles a period
// Notes: intervals 00 and 01 are set and read back, not timed
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module watchdog_interval_timer_test import wit_pkg::*; ;
  localparam int LSP = 8;
  logic CORE_CLK = 1'b0, RST_B = 1'b0, LS_CLK = 1'b0, EXT_RESET_N = 1'b1;
  logic POWER_ON_OK_N = 1'b0, SUPPLY_DIP_RESET_N = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0] PSTRB = 4'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, TIMER_IRQ, SYS_RESET_N, en_m, mode_m;
  logic [1:0] intv_m, cause_m;
  int bad_count = 0, checks_done = 0, seed = 32'h0b19, lsc = 0, lows = 0, t, t0;
  watchdog_interval_timer dut (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .LS_CLK(LS_CLK),
    .POWER_ON_OK_N(POWER_ON_OK_N),
    .SUPPLY_DIP_RESET_N(SUPPLY_DIP_RESET_N),
    .EXT_RESET_N(EXT_RESET_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PSTRB(PSTRB),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .TIMER_IRQ(TIMER_IRQ),
    .SYS_RESET_N(SYS_RESET_N)
  );
  // clocks; cycles spent in system reset
  always #2.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    lsc <= (lsc + 1) % LSP;
    LS_CLK <= lsc < LSP / 2;
    lows <= lows + !SYS_RESET_N;
  end
  // reset for three cycles, model to reset values
  task sysrst;
    RST_B <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    {RST_B, POWER_ON_OK_N, SUPPLY_DIP_RESET_N} <= 3'h7;
    {en_m, mode_m, intv_m} = 4'h0;
  endtask
  // one bus transfer checked against the model
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic [31:0] exp_rd;
    x = $random(seed);
    x[7:0] = d;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= x;
    PSTRB <= x[11:8] | 4'h1;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    // wait for the answer; ends on PREADY, with no cycle limit apart from the hang guard
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'h0;
    `CHK("error", a != CTRL_ADDR && a != STAT_ADDR, PSLVERR)
    exp_rd = (a == CTRL_ADDR) ? {28'h000_0000, en_m, mode_m, intv_m} : {29'h0, en_m, cause_m};
    if (!w)
      `CHK("rdata", exp_rd, PRDATA)
    if (w && a == CTRL_ADDR) begin
      if (!(en_m && !mode_m))
        {en_m, mode_m} = d[3:2];
      intv_m = d[1:0];
    end
  endtask
  // cycles until an irq pulse or a system reset
  task wev(input logic irq, output int c);
    c = 0;
    do begin
      @(posedge CORE_CLK);
      c++;
    end while ((irq ? TIMER_IRQ : !SYS_RESET_N) !== 1'b1 && c < 9000);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  // main sequence
  initial begin
    cause_m = CAUSE_POR;
    sysrst;
    apb(0, CTRL_ADDR, 8'h00);
    apb(0, STAT_ADDR, 8'h00);
    apb(1, 12'h100, 8'hFF);
    apb(0, CTRL_ADDR, 8'h00);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      apb(1, CTRL_ADDR, 8'h1C | 8'(i));
      apb(0, CTRL_ADDR, 8'h00);
      if (i > 1) begin
        wev(1, t);
        wev(1, t);
        `CHK("interval", (i == 3 ? 64 : 512) * LSP, t)
      end
    end
    repeat (32 * LSP) @(posedge CORE_CLK);
    apb(1, CTRL_ADDR, 8'h1F);
    wev(1, t);
    `CHK("cleared", 1, t >= 63 * LSP && t <= 66 * LSP)
    apb(1, CTRL_ADDR, 8'h07);
    wev(1, t);
    `CHK("stopped", 9000, t)
    apb(1, CTRL_ADDR, 8'h0F);
    wev(1, t);
    `CHK("restart", 1, t >= 63 * LSP && t <= 66 * LSP)
    $display("timer test done");
    sysrst;
    apb(1, CTRL_ADDR, 8'h0B);
    apb(1, CTRL_ADDR, 8'h07);
    apb(0, CTRL_ADDR, 8'h00);
    apb(0, STAT_ADDR, 8'h00);
    t0 = lows;
    for (int i = 0; i < 4; i++) begin
      repeat (40 * LSP) @(posedge CORE_CLK);
      apb(1, CTRL_ADDR, 8'hAB);
      apb(1, CTRL_ADDR, 8'h5B);
    end
    apb(1, CTRL_ADDR, 8'hAA);
    apb(1, CTRL_ADDR, 8'h5A);
    apb(1, CTRL_ADDR, 8'hAA);
    repeat (3100) @(posedge CORE_CLK);
    apb(1, CTRL_ADDR, 8'h5A);
    `CHK("no expiry", t0, lows)
    wev(0, t);
    `CHK("late key", 1, t > 900 && t < 1100)
    repeat (24) @(posedge CORE_CLK);
    cause_m = CAUSE_WDOG;
    sysrst;
    apb(0, STAT_ADDR, 8'h00);
    $display("watchdog test done");
    for (int i = 0; i < 3; i++) begin
      {POWER_ON_OK_N, SUPPLY_DIP_RESET_N, EXT_RESET_N} <= ~(3'h1 << i);
      repeat (3) @(posedge CORE_CLK);
      `CHK("held", 1'b0, SYS_RESET_N)
      {POWER_ON_OK_N, SUPPLY_DIP_RESET_N, EXT_RESET_N} <= 3'h7;
      repeat (4) @(posedge CORE_CLK);
      cause_m = i ? CAUSE_POR : CAUSE_EXT;
      apb(0, STAT_ADDR, 8'h00);
    end
    $display("reset cause test done");
    finish_test;
  end
endmodule // watchdog_interval_timer_test
bind watchdog_interval_timer wit_chk u_chk (
  .CORE_CLK(CORE_CLK),
  .RST_B(RST_B),
  .POWER_ON_OK_N(POWER_ON_OK_N),
  .SUPPLY_DIP_RESET_N(SUPPLY_DIP_RESET_N),
  .EXT_RESET_N(EXT_RESET_N),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PSTRB(PSTRB),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .TIMER_IRQ(TIMER_IRQ),
  .SYS_RESET_N(SYS_RESET_N)
);

/* File: test/wit_chk.sv */
// Purpose: port checks for the supervision timer
// Assumes: one core clock, RST_B clears the control logic
// Notes: enable and mode are shadowed from committed writes
`timescale 1ns/1ps
module wit_chk import wit_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic POWER_ON_OK_N,
  input wire logic SUPPLY_DIP_RESET_N,
  input wire logic EXT_RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_IRQ,
  input wire logic SYS_RESET_N
);
  // ---------
  // shadow
  // ---------
  logic en_r;
  logic mode_r;
  logic ok;
  logic acc;
  // no reset source active; access phase answered
  assign ok = POWER_ON_OK_N && SUPPLY_DIP_RESET_N && EXT_RESET_N;
  assign acc = PSEL && PENABLE && PREADY;
  // enable and mode follow writes unless a watchdog runs
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      en_r <= 1'b0;
      mode_r <= 1'b0;
    end else if (acc && PWRITE && PSTRB[0] && PADDR == CTRL_ADDR && !(en_r && !mode_r)) begin
      en_r <= PWDATA[3];
      mode_r <= PWDATA[2];
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence low8;
    !SYS_RESET_N [*8];
  endsequence
  a_ready_one: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not one pulse");
  a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("bad error reply");
  a_bad_addr: assert property (acc && PADDR != CTRL_ADDR && PADDR != STAT_ADDR |-> PSLVERR)
    else $error("unmapped not refused");
  a_key_zero: assert property (acc && !PWRITE && PADDR == CTRL_ADDR |->
    PRDATA[31:4] == 28'h000_0000)
    else $error("key field read nonzero");
  a_irq_pulse: assert property (TIMER_IRQ |=> !TIMER_IRQ)
    else $error("irq longer than a cycle");
  a_wdog_no_irq: assert property (en_r && !mode_r |-> !TIMER_IRQ)
    else $error("irq in watchdog mode");
  a_timer_no_rst: assert property (mode_r && ok && $past(ok) && $past(ok, 2) |->
    SYS_RESET_N)
    else $error("reset in timer mode");
  a_fire_hold: assert property ($fell(SYS_RESET_N) && ok && $past(ok) |->
    low8 ##1 low8 ##1 !SYS_RESET_N ##1 SYS_RESET_N)
    else $error("expiry reset length");
  a_held_low: assert property (!ok |=> !SYS_RESET_N)
    else $error("reset not held");
endmodule // wit_chk
